// ### design/dsm_ctrl.sv
// drive state machine controller with object access port
//
// Functional notes
// - while not ready, command writes are ignored; power supply stays on.
// - not ready moves to switch-on disabled by itself when init completes.
// - command bits: 0 switch on, 1 voltage, 2 quick stop, 3 operation, 7, 8.
// - shutdown x110, switch on / disable operation 0111, enable operation 1111.
// - disable voltage bit1 low; quick stop bit2 low bit1 high; fault reset rising bit7.
// - in fault, fault reset goes to switch-on disabled, drive stays off.
// - switched on plus enable operation gives operation enabled, drive on.
// - operation enabled plus disable operation returns to switched on, drive off.
// - from operation enabled, shutdown to ready, disable voltage to disabled.
// - quick stop from operation enabled ramps down; disable voltage then disables.
// - any fault enters fault reaction, drive off, then fault once disabled.
// - enable operation in quick stop returns to operation enabled via ramp.
// - transitions among powered-down states only change the state word.
// - state changes only by command word writes and the init, fault and disable-done pins; state word is read only.
// - bits 4 to 6 and 8 go to the mode logic, not the decoder.
// - state word bits 0,1,2,3,5,6 encode the state.
// - command writes count only while network control is selected.
`timescale 1ns/1ns
module dsm_ctrl
    import dsm_pkg::*;
#(
    parameter int SYNC_STAGES = SYNC_DEPTH
)(
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        obj_wr,
    input  wire logic        obj_rd,
    input  wire logic [15:0] obj_index,
    input  wire logic [31:0] obj_wdata,
    input  wire logic        network_src,
    input  wire logic        init_done,
    input  wire logic        fault_in,
    input  wire logic        disable_done,
    input  wire logic        target_reached,
    input  wire logic [31:0] pos_internal,
    input  wire logic [31:0] pos_user,
    input  wire logic [31:0] spd_sense,
    input  wire logic [31:0] spd_demand,
    input  wire logic [31:0] spd_now,
    input  wire logic [15:0] trq_now,
    output logic      [31:0] obj_rdata_q,
    output logic             obj_ack_q,
    output logic             obj_err_q,
    output logic      [15:0] state_word_q,
    output logic             supply_on_q,
    output logic             drive_enable_q,
    output logic             ramp_stop_q,
    output logic             ramp_start_q,
    output logic      [3:0]  mode_bits_q,
    output logic      [7:0]  mode_select_q
);

    // a single stage would let a metastable pin level reach the state machine
    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("SYNC_STAGES must be at least 2");
    end

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    // status pins come from the power stage, outside this clock domain
    logic [2:0] pin_raw;
    logic [2:0] pin_s;
    assign pin_raw = {disable_done, fault_in, init_done};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            logic [SYNC_STAGES-1:0] sh_q;
            always_ff @(posedge clock) begin
                if (srst) begin
                    sh_q <= '0;
                end else begin
                    sh_q <= {sh_q[SYNC_STAGES-2:0], pin_raw[gi]};
                end
            end
            assign pin_s[gi] = sh_q[SYNC_STAGES-1];
        end
    endgenerate

    logic init_s;
    logic fault_s;
    logic dis_done_s;
    assign init_s     = pin_s[0];
    assign fault_s    = pin_s[1];
    assign dis_done_s = pin_s[2];

    // ----------------------------------------
    // command word and decoder
    // ----------------------------------------
    dsm_state_t  state_q;
    dsm_state_t  state_d;
    logic [15:0] cmd_q;
    logic        cmd_take;

    // writes are dropped while not ready or when the network is not the source
    assign cmd_take = obj_wr && (obj_index == IDX_CMD) && network_src
                      && (state_q != ST_NRDY);

    dsm_cmd_if cif ();
    assign cif.word    = obj_wdata[15:0];
    assign cif.fr_prev = cmd_q[CW_FAULT_RST];

    dsm_cmd_decode u_dec (
        .cif (cif)
    );

    dsm_cmd_t cmd;
    assign cmd = cmd_take ? cif.cmd : CMD_NONE;

    always_ff @(posedge clock) begin
        if (srst) begin
            cmd_q <= CMD_RESET;
        end else if (cmd_take) begin
            cmd_q <= obj_wdata[15:0];
        end
    end

    // mode logic sees bits 6..4 and halt untouched by the decoder
    always_ff @(posedge clock) begin
        if (srst) begin
            mode_bits_q <= 4'h0;
        end else begin
            mode_bits_q <= {cmd_q[CW_HALT], cmd_q[CW_MODE_HI:CW_MODE_LO]};
        end
    end

    // ----------------------------------------
    // state machine
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        if (fault_s && (state_q != ST_FRA) && (state_q != ST_FLT)) begin
            state_d = ST_FRA;
        end else begin
            case (state_q)
                ST_NRDY: begin
                    if (init_s) state_d = ST_SOD;
                end
                ST_SOD: begin
                    if (cmd == CMD_SHUTDOWN) state_d = ST_RDY;
                end
                ST_RDY: begin
                    if (cmd == CMD_SWITCHON) state_d = ST_SON;
                    else if (cmd == CMD_DIS_VOLT || cmd == CMD_QSTOP) state_d = ST_SOD;
                end
                ST_SON: begin
                    if (cmd == CMD_EN_OP) state_d = ST_OPEN;
                    else if (cmd == CMD_SHUTDOWN) state_d = ST_RDY;
                    else if (cmd == CMD_DIS_VOLT || cmd == CMD_QSTOP) state_d = ST_SOD;
                end
                ST_OPEN: begin
                    if (cmd == CMD_SWITCHON) state_d = ST_SON;
                    else if (cmd == CMD_SHUTDOWN) state_d = ST_RDY;
                    else if (cmd == CMD_DIS_VOLT) state_d = ST_SOD;
                    else if (cmd == CMD_QSTOP) state_d = ST_QSA;
                end
                ST_QSA: begin
                    if (cmd == CMD_DIS_VOLT) state_d = ST_SOD;
                    else if (cmd == CMD_EN_OP) state_d = ST_OPEN;
                end
                ST_FRA: begin
                    if (dis_done_s) state_d = ST_FLT;
                end
                ST_FLT: begin
                    if (cmd == CMD_FLT_RST) state_d = ST_SOD;
                end
                default: begin
                    state_d = ST_NRDY;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_q <= ST_NRDY;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------
    // power stage outputs
    // ----------------------------------------
    // no supply switch exists, so the powered-down states leave it on
    always_ff @(posedge clock) begin
        if (srst) begin
            supply_on_q    <= 1'b1;
            drive_enable_q <= 1'b0;
            ramp_stop_q    <= 1'b0;
            ramp_start_q   <= 1'b0;
        end else begin
            supply_on_q    <= 1'b1;
            drive_enable_q <= (state_d == ST_OPEN) || (state_d == ST_QSA);
            ramp_stop_q    <= (state_d == ST_QSA);
            ramp_start_q   <= (state_q == ST_QSA) && (state_d == ST_OPEN);
        end
    end

    // ----------------------------------------
    // state word
    // ----------------------------------------
    logic [15:0] sw_d;
    always_comb begin
        sw_d = 16'h0000;
        case (state_d)
            ST_NRDY: sw_d[6:0] = 7'h00;
            ST_SOD:  sw_d[6:0] = 7'h40;
            ST_RDY:  sw_d[6:0] = 7'h21;
            ST_SON:  sw_d[6:0] = 7'h23;
            ST_OPEN: sw_d[6:0] = 7'h27;
            ST_QSA:  sw_d[6:0] = 7'h07;
            ST_FRA:  sw_d[6:0] = 7'h0f;
            ST_FLT:  sw_d[6:0] = 7'h08;
            default: sw_d[6:0] = 7'h00;
        endcase
        sw_d[SW_VOLT]   = 1'b1;
        sw_d[SW_REMOTE] = network_src;
        sw_d[SW_TARGET] = target_reached || (state_d == ST_QSA) || cmd_q[CW_HALT];
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_word_q <= 16'h0000;
        end else begin
            state_word_q <= sw_d;
        end
    end

    // ----------------------------------------
    // writable object slots
    // ----------------------------------------
    logic [31:0] rw_q [NUM_RW];
    logic [NUM_RW-1:0] rw_hit;

    generate
        for (gi = 0; gi < NUM_RW; gi++) begin : g_rw
            localparam logic [31:0] MASK = (RW_WIDTH[gi] >= 32) ? 32'hffff_ffff :
                                           ((32'h0000_0001 << RW_WIDTH[gi]) - 32'h1);
            assign rw_hit[gi] = (obj_index == RW_INDEX[gi]);
            always_ff @(posedge clock) begin
                if (srst) begin
                    rw_q[gi] <= RW_RESET;
                end else if (obj_wr && rw_hit[gi]) begin
                    rw_q[gi] <= obj_wdata & MASK;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (srst) begin
            mode_select_q <= 8'h00;
        end else begin
            mode_select_q <= rw_q[SLOT_MODE][7:0];
        end
    end

    // ----------------------------------------
    // object read and write answers
    // ----------------------------------------
    logic [31:0] rd_d;
    logic        ro_hit;
    always_comb begin
        rd_d   = 32'h0000_0000;
        ro_hit = 1'b1;
        if (obj_index == IDX_CMD) begin
            rd_d = {16'h0000, cmd_q};
        end else if (obj_index == IDX_STATE) begin
            rd_d = {16'h0000, state_word_q};
        end else if (obj_index == IDX_MODE_SHOWN) begin
            rd_d = {24'h00_0000, mode_select_q};
        end else if (obj_index == IDX_POS_INT) begin
            rd_d = pos_internal;
        end else if (obj_index == IDX_POS_USER) begin
            rd_d = pos_user;
        end else if (obj_index == IDX_SPD_SENSE) begin
            rd_d = spd_sense;
        end else if (obj_index == IDX_SPD_DEMAND) begin
            rd_d = spd_demand;
        end else if (obj_index == IDX_SPD_NOW) begin
            rd_d = spd_now;
        end else if (obj_index == IDX_TRQ_NOW) begin
            rd_d = {16'h0000, trq_now};
        end else if (obj_index == IDX_MODE_MASK) begin
            rd_d = MODES_SUPPORT;
        end else begin
            ro_hit = 1'b0;
            for (int k = 0; k < NUM_RW; k++) begin
                if (rw_hit[k]) begin
                    rd_d = rw_q[k];
                end
            end
        end
    end

    logic wr_ok;
    assign wr_ok = (obj_index == IDX_CMD) || (|rw_hit);

    // a write to a read-only or unknown index is answered with an error
    always_ff @(posedge clock) begin
        if (srst) begin
            obj_rdata_q <= 32'h0000_0000;
            obj_ack_q   <= 1'b0;
            obj_err_q   <= 1'b0;
        end else begin
            obj_ack_q <= obj_rd || obj_wr;
            obj_err_q <= (obj_rd && !(ro_hit || (|rw_hit))) || (obj_wr && !wr_ok);
            if (obj_rd) begin
                obj_rdata_q <= rd_d;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_reset_nrdy: assert property (@(posedge clock) disable iff (srst)
        $past(srst) |-> state_q == ST_NRDY)
        else $error("state not ready missing after reset");

    chk_init_advance: assert property (@(posedge clock) disable iff (srst)
        state_q == ST_NRDY && init_s && !fault_s |=> state_q == ST_SOD)
        else $error("init completion did not advance state");

    chk_nrdy_ignore: assert property (@(posedge clock) disable iff (srst)
        state_q == ST_NRDY && !init_s && !fault_s |=> state_q == ST_NRDY ##1 1'b1)
        else $error("not ready state left without init");

    chk_enable_op: assert property (@(posedge clock) disable iff (srst)
        state_q == ST_SON && cmd == CMD_EN_OP && !fault_s
        |=> state_q == ST_OPEN && drive_enable_q)
        else $error("enable operation not honoured");

    chk_disable_op: assert property (@(posedge clock) disable iff (srst)
        state_q == ST_OPEN && cmd == CMD_SWITCHON && !fault_s
        |=> state_q == ST_SON && !drive_enable_q)
        else $error("disable operation not honoured");

    chk_fault_entry: assert property (@(posedge clock) disable iff (srst)
        fault_s && state_q != ST_FRA && state_q != ST_FLT
        |=> state_q == ST_FRA && !drive_enable_q && state_word_q[3:0] == 4'hf)
        else $error("fault reaction not entered");

    chk_fault_reset: assert property (@(posedge clock) disable iff (srst)
        state_q == ST_FLT && cmd == CMD_FLT_RST && !fault_s
        |=> state_q == ST_SOD && !drive_enable_q)
        else $error("fault reset not honoured");

    chk_remote_gate: assert property (@(posedge clock) disable iff (srst)
        obj_wr && obj_index == IDX_CMD && !network_src |=> $stable(cmd_q))
        else $error("command accepted without network control");

    chk_qstop_ramp: assert property (@(posedge clock) disable iff (srst)
        state_q == ST_OPEN && cmd == CMD_QSTOP && !fault_s
        |=> state_q == ST_QSA && ramp_stop_q && drive_enable_q)
        else $error("quick stop ramp not started");

    chk_state_code: assert property (@(posedge clock) disable iff (srst)
        state_q == ST_OPEN |-> state_word_q[6:5] == 2'b01 && state_word_q[3:0] == 4'h7)
        else $error("state word wrong in operation enabled");

endmodule : dsm_ctrl

// ### design/dsm_pkg.sv
// constants and types for the drive state machine controller
package dsm_pkg;

    // ----------------------------------------
    // object indices
    // ----------------------------------------
    localparam logic [15:0] IDX_CMD        = 16'h6040;
    localparam logic [15:0] IDX_STATE      = 16'h6041;
    localparam logic [15:0] IDX_MODE_SHOWN = 16'h6061;
    localparam logic [15:0] IDX_POS_INT    = 16'h6063;
    localparam logic [15:0] IDX_POS_USER   = 16'h6064;
    localparam logic [15:0] IDX_SPD_SENSE  = 16'h6069;
    localparam logic [15:0] IDX_SPD_DEMAND = 16'h606b;
    localparam logic [15:0] IDX_SPD_NOW    = 16'h606c;
    localparam logic [15:0] IDX_TRQ_NOW    = 16'h6077;
    localparam logic [15:0] IDX_MODE_MASK  = 16'h6502;

    // ----------------------------------------
    // writable objects held in the slot array
    // ----------------------------------------
    localparam int          NUM_RW    = 13;
    localparam int          SLOT_MODE = 0;
    localparam logic [15:0] RW_INDEX [NUM_RW] = '{
        16'h6060, 16'h6071, 16'h607a, 16'h6081, 16'h6083, 16'h6084, 16'h6086,
        16'h6087, 16'h6088, 16'h608f, 16'h6091, 16'h6092, 16'h60ff};
    localparam int          RW_WIDTH [NUM_RW] = '{
        8, 16, 32, 32, 32, 32, 16, 32, 16, 32, 32, 32, 32};
    localparam logic [31:0] RW_RESET      = 32'h0000_0000;
    localparam logic [15:0] CMD_RESET     = 16'h0000;
    localparam logic [31:0] MODES_SUPPORT = 32'h0000_000d;

    // ----------------------------------------
    // command word and state word fields
    // ----------------------------------------
    localparam int CW_SWITCH_ON = 0;
    localparam int CW_EN_VOLT   = 1;
    localparam int CW_QSTOP     = 2;
    localparam int CW_EN_OP     = 3;
    localparam int CW_MODE_LO   = 4;
    localparam int CW_MODE_HI   = 6;
    localparam int CW_FAULT_RST = 7;
    localparam int CW_HALT      = 8;
    localparam int SW_VOLT      = 4;
    localparam int SW_REMOTE    = 9;
    localparam int SW_TARGET    = 10;
    localparam int SYNC_DEPTH   = 2;

    typedef enum logic [7:0] {
        ST_NRDY = 8'h01,
        ST_SOD  = 8'h02,
        ST_RDY  = 8'h04,
        ST_SON  = 8'h08,
        ST_OPEN = 8'h10,
        ST_QSA  = 8'h20,
        ST_FRA  = 8'h40,
        ST_FLT  = 8'h80
    } dsm_state_t;

    typedef enum logic [6:0] {
        CMD_NONE     = 7'h00,
        CMD_SHUTDOWN = 7'h01,
        CMD_SWITCHON = 7'h02,
        CMD_DIS_VOLT = 7'h04,
        CMD_QSTOP    = 7'h08,
        CMD_EN_OP    = 7'h10,
        CMD_FLT_RST  = 7'h20,
        CMD_SPARE    = 7'h40
    } dsm_cmd_t;

endpackage : dsm_pkg

// ### design/dsm_cmd_if.sv
// command word carrier between controller and decoder
`timescale 1ns/1ns
interface dsm_cmd_if;
    import dsm_pkg::*;
    logic [15:0] word;
    logic        fr_prev;
    dsm_cmd_t    cmd;
    modport dec (input word, input fr_prev, output cmd);
    modport ctl (output word, output fr_prev, input cmd);
endinterface : dsm_cmd_if

// ### design/dsm_cmd_decode.sv
// command word decoder
`timescale 1ns/1ns
module dsm_cmd_decode
    import dsm_pkg::*;
(
    dsm_cmd_if.dec cif
);

    // ----------------------------------------
    // decode
    // ----------------------------------------
    // halt and bits 6..4 are left to the mode logic
    always_comb begin
        cif.cmd = CMD_NONE;
        if (cif.word[CW_FAULT_RST]) begin
            if (!cif.fr_prev) begin
                cif.cmd = CMD_FLT_RST;
            end
        end else if (!cif.word[CW_EN_VOLT]) begin
            cif.cmd = CMD_DIS_VOLT;
        end else if (!cif.word[CW_QSTOP]) begin
            cif.cmd = CMD_QSTOP;
        end else if (!cif.word[CW_SWITCH_ON]) begin
            cif.cmd = CMD_SHUTDOWN;
        end else if (cif.word[CW_EN_OP]) begin
            cif.cmd = CMD_EN_OP;
        end else begin
            cif.cmd = CMD_SWITCHON; // also disable operation
        end
    end

endmodule : dsm_cmd_decode

// ### tb/dsm_master_model.sv
// network master model that reads and writes drive objects
`timescale 1ns/1ns
module dsm_master_model (
    input  wire logic        clock,
    output logic             obj_wr,
    output logic             obj_rd,
    output logic      [15:0] obj_index,
    output logic      [31:0] obj_wdata,
    input  wire logic [31:0] obj_rdata_q,
    input  wire logic        obj_ack_q,
    input  wire logic        obj_err_q
);
    initial begin
        obj_wr    = 1'b0;
        obj_rd    = 1'b0;
        obj_index = 16'h0000;
        obj_wdata = 32'h0000_0000;
    end

    // ----------------------------------------
    // one object access per call
    // ----------------------------------------
    // the master steers the drive only through object accesses; the status pins are driven by the bench top
    task automatic access(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                          output logic [31:0] rd, output logic ack, output logic err);
        @(posedge clock);
        #1;
        obj_wr    = wr;
        obj_rd    = !wr;
        obj_index = idx;
        obj_wdata = wd;
        @(posedge clock);
        #1;
        rd        = obj_rdata_q;
        ack       = obj_ack_q;
        err       = obj_err_q;
        obj_wr    = 1'b0;
        obj_rd    = 1'b0;
        // released index and data lines are inverted so a late sample never sees a stale copy
        obj_index = ~idx;
        obj_wdata = ~wd;
    endtask : access
endmodule : dsm_master_model

// ### tb/drive_state_machine_ctrl_tb_top.sv
// self-checking bench for the drive state machine controller
`timescale 1ns/1ns
module drive_state_machine_ctrl_tb_top;
    import dsm_pkg::*;
    logic        clock = 1'b0;
    logic        srst  = 1'b1;
    logic        obj_wr, obj_rd, network_src, init_done, fault_in, disable_done;
    logic        target_reached = 1'b0;
    logic [15:0] obj_index, trq_now, state_word_q;
    logic [31:0] obj_wdata, obj_rdata_q, pos_internal, pos_user, spd_sense, spd_demand, spd_now;
    logic        obj_ack_q, obj_err_q, supply_on_q, drive_enable_q, ramp_stop_q, ramp_start_q;
    logic [3:0]  mode_bits_q, exp_mode;
    logic [7:0]  mode_select_q;
    int          error_cnt = 0;
    int          cmp_count = 0;
    dsm_state_t  exp_st;
    logic        exp_fr, ack, err;
    logic [31:0] rd, d, m;
    logic [15:0] ro_idx [7];
    logic [31:0] ro_val [7];
    localparam logic [15:0] SEQ [25] = '{16'h0006, 16'h0007, 16'h000f, 16'h000b, 16'h000f,
        16'h0007, 16'h000f, 16'h0006, 16'h0007, 16'h000f, 16'h0000, 16'h0006, 16'h0007,
        16'h000f, 16'h000b, 16'h0007, 16'h0001, 16'h0006, 16'h000f, 16'h0002, 16'h0006,
        16'h0007, 16'h0006, 16'h0007, 16'h0005};

    always #25 clock = ~clock;

    dsm_ctrl #(.SYNC_STAGES(2)) DUT (.clock, .srst, .obj_wr, .obj_rd, .obj_index, .obj_wdata,
        .network_src, .init_done, .fault_in, .disable_done, .target_reached, .pos_internal,
        .pos_user, .spd_sense, .spd_demand, .spd_now, .trq_now, .obj_rdata_q, .obj_ack_q,
        .obj_err_q, .state_word_q, .supply_on_q, .drive_enable_q, .ramp_stop_q, .ramp_start_q,
        .mode_bits_q, .mode_select_q);

    dsm_master_model u_mst (.clock, .obj_wr, .obj_rd, .obj_index, .obj_wdata, .obj_rdata_q,
        .obj_ack_q, .obj_err_q);

    // ----------------------------------------
    // expectation and check helpers
    // ----------------------------------------
    function automatic dsm_state_t exp_next(dsm_state_t s, logic [15:0] w, logic fr_prev);
        if (s == ST_FLT) return (w[7] && !fr_prev) ? ST_SOD : s;
        if (w[7]) return s;
        if (!w[1]) return (s inside {ST_RDY, ST_SON, ST_OPEN, ST_QSA}) ? ST_SOD : s;
        if (!w[2]) return (s == ST_OPEN) ? ST_QSA : ((s inside {ST_RDY, ST_SON}) ? ST_SOD : s);
        if (!w[0]) return (s inside {ST_SOD, ST_SON, ST_OPEN}) ? ST_RDY : s;
        if (!w[3]) return (s inside {ST_RDY, ST_OPEN}) ? ST_SON : s;
        return (s inside {ST_SON, ST_QSA}) ? ST_OPEN : s;
    endfunction : exp_next

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic chk_sw(input logic [15:0] word);
        logic [15:0] sm, sv;
        sm = (exp_st inside {ST_RDY, ST_SON, ST_OPEN, ST_QSA}) ? 16'h006f : 16'h004f;
        case (exp_st)
            ST_SOD:  sv = 16'h0040;
            ST_RDY:  sv = 16'h0021;
            ST_SON:  sv = 16'h0023;
            ST_OPEN: sv = 16'h0027;
            ST_QSA:  sv = 16'h0007;
            ST_FRA:  sv = 16'h000f;
            ST_FLT:  sv = 16'h0008;
            default: sv = 16'h0000;
        endcase
        if (exp_st != ST_NRDY) begin
            sm = sm | 16'h0210;
            sv = sv | 16'h0010 | {6'h00, network_src, 9'h000};
        end
        chk({16'h0000, word & sm}, {16'h0000, sv}, "state word");
    endtask : chk_sw

    task automatic chk_state();
        chk_sw(state_word_q);
        chk({31'h0, drive_enable_q}, {31'h0, exp_st inside {ST_OPEN, ST_QSA}}, "drive");
        chk({31'h0, ramp_stop_q}, {31'h0, exp_st == ST_QSA}, "ramp stop");
        chk({31'h0, supply_on_q}, 32'h1, "supply");
    endtask : chk_state

    task automatic obj(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                       input logic e);
        u_mst.access(wr, idx, wd, rd, ack, err);
        chk({31'h0, ack}, 32'h1, "ack");
        chk({31'h0, err}, {31'h0, e}, "refusal");
    endtask : obj

    task automatic cmd(input logic [15:0] w);
        dsm_state_t nx;
        logic       live;
        live = network_src && exp_st != ST_NRDY;
        nx = live ? exp_next(exp_st, w, exp_fr) : exp_st;
        obj(1'b1, IDX_CMD, {16'h0000, w}, 1'b0);
        chk({31'h0, ramp_start_q}, {31'h0, exp_st == ST_QSA && nx == ST_OPEN}, "ramp");
        exp_st = nx;
        if (live) begin
            exp_fr = w[7];
            exp_mode = {w[8], w[6:4]};
        end
        chk_state();
        obj(1'b0, IDX_STATE, 32'h0, 1'b0);
        chk_sw(rd[15:0]);
        chk({28'h0, mode_bits_q}, {28'h0, exp_mode}, "mode bits");
    endtask : cmd

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h9833402a));
        {network_src, init_done, fault_in, disable_done} = 4'b1000;
        {pos_internal, pos_user, spd_sense} = {$urandom, $urandom, $urandom};
        {spd_demand, spd_now, trq_now} = {$urandom, $urandom, 16'($urandom)};
        ro_idx = '{IDX_POS_INT, IDX_POS_USER, IDX_SPD_SENSE, IDX_SPD_DEMAND, IDX_SPD_NOW,
                   IDX_TRQ_NOW, IDX_MODE_MASK};
        ro_val = '{pos_internal, pos_user, spd_sense, spd_demand, spd_now,
                   {16'h0000, trq_now}, MODES_SUPPORT};
        exp_st = ST_NRDY;
        exp_fr = 1'b0;
        exp_mode = 4'h0;
        tick(8);
        srst = 1'b0;
        chk_state();
        cmd(16'h0006);
        init_done = 1'b1;
        tick(3);
        exp_st = ST_SOD;
        chk_state();
        network_src = 1'b0;
        cmd(16'h0006);
        network_src = 1'b1;
        $display("test startup done");
        foreach (SEQ[i]) cmd(SEQ[i]);
        $display("test transitions done");
        for (int i = 0; i < NUM_RW; i++) begin
            d = $urandom;
            m = (RW_WIDTH[i] == 32) ? 32'hffff_ffff : (32'h1 << RW_WIDTH[i]) - 32'h1;
            obj(1'b1, RW_INDEX[i], d, 1'b0);
            obj(1'b0, RW_INDEX[i], 32'h0, 1'b0);
            chk(rd, d & m, "readback");
        end
        obj(1'b1, RW_INDEX[SLOT_MODE], 32'h0000_0003, 1'b0);
        obj(1'b0, IDX_MODE_SHOWN, 32'h0, 1'b0);
        chk(rd, 32'h3, "mode shown");
        chk({24'h0, mode_select_q}, 32'h3, "mode select");
        foreach (ro_idx[i]) begin
            obj(1'b1, ro_idx[i], $urandom, 1'b1);
            obj(1'b0, ro_idx[i], 32'h0, 1'b0);
            chk(rd, ro_val[i], "read only value");
        end
        obj(1'b1, IDX_STATE, 32'h0, 1'b1);
        obj(1'b1, 16'h1234, 32'h0, 1'b1);
        obj(1'b0, 16'h1234, 32'h0, 1'b1);
        chk_state();
        $display("test objects done");
        repeat (300) begin
            network_src = ($urandom_range(7) != 0);
            cmd(16'($urandom) & 16'hff7f);
        end
        network_src = 1'b1;
        $display("test random done");
        cmd(16'h0000);
        for (int i = 0; i < 3; i++) cmd(SEQ[i]);
        fault_in = 1'b1;
        tick(3);
        exp_st = ST_FRA;
        chk_state();
        cmd(16'h000f);
        disable_done = 1'b1;
        tick(3);
        exp_st = ST_FLT;
        chk_state();
        {fault_in, disable_done} = 2'b00;
        tick(3);
        cmd(16'h0080);
        $display("test fault done");
        srst = 1'b1;
        tick(2);
        srst = 1'b0;
        exp_st = ST_NRDY;
        exp_fr = 1'b0;
        exp_mode = 4'h0;
        chk_state();
        tick(3);
        exp_st = ST_SOD;
        chk_state();
        $display("test second reset done");
        stop_test();
    end

    initial begin
        #2_000_000;
        error_cnt++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule : drive_state_machine_ctrl_tb_top
